// ===== core/lsru_consts.svh
// Opcodes, field positions and reset values of the logic, shift and rotate unit.
`ifndef LSRU_CONSTS_SVH
`define LSRU_CONSTS_SVH
`define LSRU_OP_RTYPE       6'h3a
`define LSRU_OP_ORHI        6'h34
`define LSRU_OP_ORI         6'h14
`define LSRU_X_OR           6'h16
`define LSRU_X_RDCTL        6'h26
`define LSRU_X_RET          6'h05
`define LSRU_X_ROL          6'h03
`define LSRU_X_ROLI         6'h02
`define LSRU_X_ROR          6'h0b
`define LSRU_X_SHL_VAR      6'h13
`define LSRU_X_SLLI         6'h12
`define LSRU_X_SRA          6'h3b
`define LSRU_X_SRAI         6'h3a
`define LSRU_X_SRL          6'h1b
`define LSRU_X_SRLI         6'h1a
`define LSRU_A_HI           31
`define LSRU_A_LO           27
`define LSRU_B_HI           26
`define LSRU_B_LO           22
`define LSRU_C_HI           21
`define LSRU_C_LO           17
`define LSRU_X_HI           16
`define LSRU_X_LO           11
`define LSRU_N_HI           10
`define LSRU_N_LO           6
`define LSRU_I16_HI         21
`define LSRU_I16_LO         6
`define LSRU_P_HI           5
`define LSRU_P_LO           0
`define LSRU_NREGS          32
`define LSRU_NCTL           32
`define LSRU_RESET_WORD     32'h0000_0000
`define LSRU_LINK_REG       5'h1f
`endif

// ===== core/lsru_pkg.sv
// Types shared by the logic, shift and rotate unit.
package lsru_pkg;
   typedef enum logic [3:0] {
      LSRU_NONE, LSRU_OR, LSRU_ORHI, LSRU_ORI, LSRU_RDCTL, LSRU_RET,
      LSRU_ROL, LSRU_ROR, LSRU_SHL, LSRU_SRA, LSRU_SRL, LSRU_ILLEGAL
   } lsru_op_e;
   typedef struct packed {
      lsru_op_e   op;
      logic [4:0] a_idx;
      logic [4:0] b_idx;
      logic [4:0] c_idx;
      logic [4:0] dst_idx;
      logic [4:0] shift_amount_imm;
      logic       imm_amt;
      logic [15:0] immediate_sixteen;
   } lsru_dec_s;
   typedef struct packed {
      logic        wr_en;
      logic [4:0]  wr_idx;
      logic [31:0] wr_data;
      logic        pc_load;
      logic [31:0] pc_target;
      logic        exc_super;
      logic        exc_misalign;
      logic        exc_illegal;
      logic        done;
   } lsru_res_s;
   typedef struct packed {
      lsru_res_s res;
   } lsru_state_s;
endpackage

// ===== core/lsru_decoder.sv
// Instruction field decoder for the logic, shift and rotate unit.
`include "lsru_consts.svh"
module lsru_decoder
   import lsru_pkg::*;
(
   // Instruction word
   input  wire logic [31:0] instr,
   // Decoded fields
   output lsru_dec_s        dec
);
   logic [5:0] prim;
   logic [5:0] ext;

   always_comb
   begin
      prim        = instr[`LSRU_P_HI:`LSRU_P_LO];
      ext         = instr[`LSRU_X_HI:`LSRU_X_LO];
      dec         = '0;
      dec.a_idx   = instr[`LSRU_A_HI:`LSRU_A_LO];
      dec.b_idx   = instr[`LSRU_B_HI:`LSRU_B_LO];
      dec.c_idx   = instr[`LSRU_C_HI:`LSRU_C_LO];
      dec.shift_amount_imm  = instr[`LSRU_N_HI:`LSRU_N_LO];
      dec.immediate_sixteen = instr[`LSRU_I16_HI:`LSRU_I16_LO];
      dec.dst_idx = dec.c_idx;
      dec.op      = LSRU_ILLEGAL;
      if (prim == `LSRU_OP_ORHI)
      begin
         dec.op      = LSRU_ORHI;
         dec.dst_idx = dec.b_idx;
      end
      else if (prim == `LSRU_OP_ORI)
      begin
         dec.op      = LSRU_ORI;
         dec.dst_idx = dec.b_idx;
      end
      else if (prim == `LSRU_OP_RTYPE)
      begin
         unique case (ext)
            `LSRU_X_OR:    dec.op = LSRU_OR;
            `LSRU_X_RDCTL: dec.op = LSRU_RDCTL;
            `LSRU_X_RET:   dec.op = LSRU_RET;
            `LSRU_X_ROL:   dec.op = LSRU_ROL;
            `LSRU_X_ROR:   dec.op = LSRU_ROR;
            `LSRU_X_SHL_VAR: dec.op = LSRU_SHL;
            `LSRU_X_SRA:   dec.op = LSRU_SRA;
            `LSRU_X_SRL:   dec.op = LSRU_SRL;
            `LSRU_X_ROLI:
            begin
               dec.op      = LSRU_ROL;
               dec.imm_amt = 1'b1;
            end
            `LSRU_X_SLLI:
            begin
               dec.op      = LSRU_SHL;
               dec.imm_amt = 1'b1;
            end
            `LSRU_X_SRAI:
            begin
               dec.op      = LSRU_SRA;
               dec.imm_amt = 1'b1;
            end
            `LSRU_X_SRLI:
            begin
               dec.op      = LSRU_SRL;
               dec.imm_amt = 1'b1;
            end
            default:       dec.op = LSRU_ILLEGAL;
         endcase
      end
   end
endmodule

// ===== core/lsru_unit.sv
// Logic, shift and rotate execution unit with its general register file.
`include "lsru_consts.svh"
// Notes on behaviour
// - Register OR writes source_a_reg OR source_b_reg into dest_c_reg, no exception.
// - High-half OR: immediate in bits 31..16, low half zero, ORed, written to B.
// - Low OR: immediate zero-extended to 32 bits, ORed with source_a_reg, written to B.
// - Control read copies indexed control register; outside supervisor mode it faults.
// - Return loads program counter from link register; misaligned target faults.
// - Rotate left by source_b_reg bits 4..0; upper bits ignored.
// - Rotate left by five-bit immediate, result to dest_c_reg.
// - Rotate right by source_b_reg bits 4..0; upper bits ignored.
// - Shift left by source_b_reg bits 4..0, zero fill, to dest_c_reg.
// - Shift left by five-bit immediate, zero fill, to dest_c_reg.
// - Arithmetic right shift by source_b_reg bits 4..0, sign fill.
// - Arithmetic right shift by five-bit immediate, sign fill, to dest_c_reg.
// - Logical right shift by source_b_reg bits 4..0, zero fill.
module lsru_unit
   import lsru_pkg::*;
#(
   parameter int NREGS = `LSRU_NREGS,
   parameter int NCTL  = `LSRU_NCTL
)
(
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   // Instruction issue
   input  wire logic                 issue_valid,
   input  wire logic [31:0]          instr,
   input  wire logic                 supervisor_mode,
   // Control register file view
   input  wire logic [NCTL*32-1:0]   ctl_regs_flat,
   // Register file debug read port
   input  wire logic [4:0]           dbg_idx,
   output logic      [31:0]          dbg_data,
   // Results
   output lsru_res_s                 res
);
   lsru_dec_s   dec;
   lsru_state_s st_ff;
   lsru_state_s nxt_st;
   logic [31:0] gpr_ff [NREGS];
   logic [31:0] opa;
   logic [31:0] opb;
   logic [4:0]  amt;
   logic [31:0] rot_l;
   logic [31:0] rot_r;

   // Register zero is never stored, so it reads as zero everywhere.
   function automatic logic [31:0] rd_gpr(input logic [4:0] idx, input logic [31:0] val);
      rd_gpr = (idx == 5'h00) ? 32'h0000_0000 : val;
   endfunction

   function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] n);
      logic [63:0] dbl;
      dbl  = {v, v} << n;
      rotl = dbl[63:32];
   endfunction

   lsru_decoder u_dec
   (
      .instr (instr),
      .dec   (dec)
   );

   assign opa      = rd_gpr(dec.a_idx, gpr_ff[dec.a_idx]);
   assign opb      = rd_gpr(dec.b_idx, gpr_ff[dec.b_idx]);
   // Only five bits of the amount are looked at; the rest of source_b_reg is don't-care.
   assign amt      = dec.imm_amt ? dec.shift_amount_imm : opb[4:0];
   assign rot_l    = rotl(opa, amt);
   assign rot_r    = rotl(opa, 5'(6'd32 - {1'b0, amt}));
   assign dbg_data = rd_gpr(dbg_idx, gpr_ff[dbg_idx]);
   assign res      = st_ff.res;

   always_comb
   begin
      logic [31:0] target;
      target              = rd_gpr(`LSRU_LINK_REG, gpr_ff[`LSRU_LINK_REG]);
      nxt_st              = '0;
      if (issue_valid)
      begin
         nxt_st.res.wr_idx = dec.dst_idx;
         nxt_st.res.done  = 1'b1;
         nxt_st.res.wr_en = 1'b1;
         unique case (dec.op)
            LSRU_OR:    nxt_st.res.wr_data = opa | opb;
            LSRU_ORHI:  nxt_st.res.wr_data = opa | {dec.immediate_sixteen, 16'h0000};
            LSRU_ORI:   nxt_st.res.wr_data = opa | {16'h0000, dec.immediate_sixteen};
            LSRU_ROL:   nxt_st.res.wr_data = rot_l;
            LSRU_ROR:   nxt_st.res.wr_data = rot_r;
            LSRU_SHL:   nxt_st.res.wr_data = opa << amt;
            LSRU_SRA:   nxt_st.res.wr_data = 32'($signed(opa) >>> amt);
            LSRU_SRL:   nxt_st.res.wr_data = opa >> amt;
            LSRU_RDCTL:
            begin
               if (supervisor_mode)
                  nxt_st.res.wr_data = ctl_regs_flat[dec.shift_amount_imm*32 +: 32];
               else
               begin
                  nxt_st.res.wr_en     = 1'b0;
                  nxt_st.res.exc_super = 1'b1;
               end
            end
            LSRU_RET:
            begin
               nxt_st.res.wr_en = 1'b0;
               if (target[1:0] != 2'b00)
                  nxt_st.res.exc_misalign = 1'b1;
               else
               begin
                  nxt_st.res.pc_load   = 1'b1;
                  nxt_st.res.pc_target = target;
               end
            end
            LSRU_NONE, LSRU_ILLEGAL:
            begin
               nxt_st.res.wr_en       = 1'b0;
               nxt_st.res.exc_illegal = 1'b1;
            end
         endcase
         if (dec.dst_idx == 5'h00)
            nxt_st.res.wr_en = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         st_ff <= '0;
         for (int i = 0; i < NREGS; i++)
            gpr_ff[i] <= `LSRU_RESET_WORD;
      end
      else
      begin
         st_ff <= nxt_st;
         // Write-back lands two cycles after issue, one cycle after the registered result.
         if (st_ff.res.wr_en)
            gpr_ff[st_ff.res.wr_idx] <= st_ff.res.wr_data;
      end
   end
endmodule

// ===== tb/lsru_unit_props.sv
// Port-level checks for the logic, shift and rotate unit.
`include "lsru_consts.svh"
module lsru_unit_props
   import lsru_pkg::*;
#(
   parameter int NCTL = `LSRU_NCTL
)
(
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               nrst,
   // Issue side
   input wire logic               issue_valid,
   input wire logic [31:0]        instr,
   input wire logic               supervisor_mode,
   input wire logic [NCTL*32-1:0] ctl_regs_flat,
   input wire logic [4:0]         dbg_idx,
   // Results
   input wire logic [31:0]        dbg_data,
   input wire lsru_res_s          res
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ins_ff;
   logic [31:0] ctl_ff;
   wire logic       rt    = issue_valid && instr[5:0] == `LSRU_OP_RTYPE;
   wire logic [5:0] xop   = instr[16:11];
   wire logic       rdctl = rt && xop == `LSRU_X_RDCTL;
   wire logic [5:0] op    = instr[5:0];
   // Issue-cycle copies let the a_orhi_high, a_ori_low and a_ctl_copy consequents compare against what was asked for.
   always_ff @(posedge ref_clk)
   begin
      ins_ff <= instr;
      ctl_ff <= ctl_regs_flat[instr[10:6]*32 +: 32];
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_done_after_issue: assert property (issue_valid |=> res.done)
      else $error("done missing one cycle after issue");
   a_idle_quiet: assert property (!issue_valid |=> !res.done && !res.wr_en)
      else $error("result raised without an issue");
   a_orhi_high: assert property (issue_valid && op == `LSRU_OP_ORHI && instr[31:27] == 5'h00 |=>
      res.wr_idx == ins_ff[26:22] && res.wr_data == {ins_ff[21:6], 16'h0000})
      else $error("high-half or result wrong");
   a_ori_low: assert property (issue_valid && op == `LSRU_OP_ORI && instr[26:22] != 5'h00 |=>
      res.wr_idx == ins_ff[26:22] && (res.wr_data[15:0] & ins_ff[21:6]) == ins_ff[21:6])
      else $error("low or result wrong");
   a_ctl_copy: assert property (rdctl && supervisor_mode && instr[21:17] != 5'h00 |=>
      res.wr_en && res.wr_idx == ins_ff[21:17] && res.wr_data == ctl_ff && !res.exc_super)
      else $error("control read value wrong");
   a_user_fault: assert property (rdctl && !supervisor_mode |=> res.exc_super && !res.wr_en)
      else $error("control read outside supervisor not faulted");
   a_zero_dest: assert property (rt && xop == `LSRU_X_OR && instr[21:17] == 5'h00 |=> !res.wr_en)
      else $error("write to register zero enabled");
   a_ret_outcome: assert property (rt && xop == `LSRU_X_RET |=> !res.wr_en && (res.pc_load ^ res.exc_misalign))
      else $error("return outcome wrong");
   a_pc_aligned: assert property (res.pc_load |-> res.pc_target[1:0] == 2'h0)
      else $error("misaligned return target loaded");
   a_illegal_op: assert property (issue_valid && op == 6'h00 |=> res.exc_illegal && !res.wr_en)
      else $error("foreign opcode not flagged");
   c_ctl_fault: cover property (res.exc_super);
   c_misalign: cover property (res.exc_misalign);
   c_ret_taken: cover property (res.pc_load);
   c_back_to_back: cover property (issue_valid ##1 issue_valid);
endmodule
bind lsru_unit lsru_unit_props #(.NCTL(NCTL)) i_lsru_unit_props (.ref_clk(ref_clk), .nrst(nrst),
   .issue_valid(issue_valid), .instr(instr), .supervisor_mode(supervisor_mode),
   .ctl_regs_flat(ctl_regs_flat), .dbg_idx(dbg_idx), .dbg_data(dbg_data), .res(res));

// ===== tb/lsru_unit_test.sv
// Self-checking bench for the logic, shift and rotate unit.
`include "lsru_consts.svh"
module lsru_unit_test
   import lsru_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          ref_clk = 1'b0;
   logic          nrst = 1'b0;
   logic          issue_valid = 1'b0;
   logic [31:0]   instr = 32'h0000_0000;
   logic          supervisor_mode = 1'b1;
   logic [1023:0] ctl_regs_flat;
   logic [4:0]    dbg_idx = 5'h00;
   logic [31:0]   dbg_data;
   lsru_res_s     res;
   lsru_res_s     got;
   int            error_cnt = 0;
   int            checks_done = 0;
   always #10 ref_clk = ~ref_clk;
   lsru_unit #(.NCTL(32)) i_lsru_unit (.ref_clk(ref_clk), .nrst(nrst), .issue_valid(issue_valid),
      .instr(instr), .supervisor_mode(supervisor_mode), .ctl_regs_flat(ctl_regs_flat),
      .dbg_idx(dbg_idx), .dbg_data(dbg_data), .res(res));
   function automatic logic [31:0] rt_w(input logic [4:0] a, b, c, input logic [5:0] x, input logic [4:0] n);
      return {a, b, c, x, n, `LSRU_OP_RTYPE};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   // One idle cycle follows every issue, since results are not forwarded.
   task automatic ex(input logic [31:0] w, input logic sup);
      issue_valid = 1'b1;
      instr = w;
      supervisor_mode = sup;
      @(negedge ref_clk);
      issue_valid = 1'b0;
      got = res;
      chk({31'h0, got.done}, 32'h0000_0001);
      @(negedge ref_clk);
   endtask
   task automatic ld(input logic [4:0] r, input logic [31:0] v);
      dbg_idx = r;
      ex({5'h00, r, v[31:16], `LSRU_OP_ORHI}, 1'b1);
      ex({r, r, v[15:0], `LSRU_OP_ORI}, 1'b1);
      chk(dbg_data, v);
   endtask
   task automatic t_or();
      ld(5'h01, 32'h8000_0001);
      ld(5'h04, 32'h0f0f_0000);
      ex(rt_w(5'h01, 5'h04, 5'h05, `LSRU_X_OR, 5'h00), 1'b1);
      chk(got.wr_data, 32'h8f0f_0001);
      chk({29'h0, got.exc_super, got.exc_misalign, got.exc_illegal}, 32'h0000_0000);
      ex({5'h01, 5'h02, 16'hffff, `LSRU_OP_ORI}, 1'b1);
      chk(got.wr_data, 32'h8000_ffff);
      ex({5'h01, 5'h03, 16'h1234, `LSRU_OP_ORHI}, 1'b1);
      chk(got.wr_data, 32'h9234_0001);
      dbg_idx = 5'h00;
      ex(rt_w(5'h01, 5'h04, 5'h00, `LSRU_X_OR, 5'h00), 1'b1);
      chk({31'h0, got.wr_en}, 32'h0000_0000);
      chk(dbg_data, 32'h0000_0000);
   endtask
   task automatic t_shift();
      logic [5:0] xs [9] = '{`LSRU_X_ROL, `LSRU_X_ROR, `LSRU_X_SHL_VAR, `LSRU_X_SRA, `LSRU_X_SRL,
                            `LSRU_X_ROLI, `LSRU_X_SLLI, `LSRU_X_SRAI, `LSRU_X_SRLI};
      logic [31:0] a;
      logic [31:0] e;
      int s;
      // Upper amount bits are set so that a design using them gives a wrong result.
      ld(5'h06, 32'hffff_ffe4);
      a = 32'h8000_0001;
      for (int i = 0; i < 9; i++)
      begin
         s = (i < 5) ? 4 : 31;
         ex(rt_w(5'h01, (i < 5) ? 5'h06 : 5'h00, 5'h07, xs[i], (i < 5) ? 5'h00 : 5'h1f), 1'b1);
         case (i)
            0, 5: e = (a << s) | (a >> (32 - s));
            1: e = (a >> s) | (a << (32 - s));
            2, 6: e = a << s;
            3, 7: e = $signed(a) >>> s;
            default: e = a >> s;
         endcase
         chk(got.wr_data, e);
         chk({27'h0, got.wr_idx}, 32'h0000_0007);
      end
   endtask
   task automatic t_ctl();
      ex(rt_w(5'h00, 5'h00, 5'h08, `LSRU_X_RDCTL, 5'h1f), 1'b1);
      chk(got.wr_data, 32'h5a00_001f);
      chk({27'h0, got.wr_idx}, 32'h0000_0008);
      ex(rt_w(5'h00, 5'h00, 5'h08, `LSRU_X_RDCTL, 5'h03), 1'b0);
      chk({30'h0, got.exc_super, got.wr_en}, 32'h0000_0002);
   endtask
   task automatic t_ret();
      ld(5'h1f, 32'h0000_1000);
      ex(rt_w(5'h1f, 5'h00, 5'h00, `LSRU_X_RET, 5'h00), 1'b1);
      chk(got.pc_target, 32'h0000_1000);
      chk({30'h0, got.pc_load, got.exc_misalign}, 32'h0000_0002);
      ld(5'h1f, 32'h0000_1002);
      ex(rt_w(5'h1f, 5'h00, 5'h00, `LSRU_X_RET, 5'h00), 1'b1);
      chk({30'h0, got.pc_load, got.exc_misalign}, 32'h0000_0001);
      ex(32'h0000_0000, 1'b1);
      chk({31'h0, got.exc_illegal}, 32'h0000_0001);
   endtask
   task automatic t_b2b();
      issue_valid = 1'b1;
      instr = rt_w(5'h01, 5'h04, 5'h09, `LSRU_X_OR, 5'h00);
      @(negedge ref_clk);
      instr = rt_w(5'h04, 5'h00, 5'h0a, `LSRU_X_SLLI, 5'h04);
      chk(res.wr_data, 32'h8f0f_0001);
      @(negedge ref_clk);
      issue_valid = 1'b0;
      chk(res.wr_data, 32'hf0f0_0000);
      @(negedge ref_clk);
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      for (int i = 0; i < 32; i++)
         ctl_regs_flat[i*32 +: 32] = 32'h5a00_0000 | i;
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      t_or();
      t_shift();
      t_ctl();
      t_ret();
      t_b2b();
      final_report();
   end
   // The tests need about seventy cycles, so this limit only trips on a hang.
   initial
   begin
      repeat (2000) @(posedge ref_clk);
      error_cnt++;
      final_report();
   end
endmodule
